//--- rtl/cca_pkg.sv
package cca_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CH = 3;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_MODE    = 8'h04;
  localparam logic [7:0] OFS_CNTL    = 8'h08;
  localparam logic [7:0] OFS_CNTH    = 8'h0C;
  localparam logic [7:0] OFS_PWM     = 8'h10;
  localparam logic [7:0] OFS_PINS    = 8'h14;
  localparam logic [7:0] OFS_CH_BASE = 8'h20;
  localparam logic [7:0] CH_STRIDE   = 8'h10;
  localparam logic [7:0] CH_OFS_MODE = 8'h00;
  localparam logic [7:0] CH_OFS_LOW  = 8'h04;
  localparam logic [7:0] CH_OFS_HIGH = 8'h08;

  // counter_control_reg bits (channel flags in the low bits)
  localparam int unsigned CTRL_CF  = 7;
  localparam int unsigned CTRL_RUN = 6;
  // counter_mode_reg bits
  localparam int unsigned MODE_IDLE = 7;
  localparam int unsigned MODE_TB   = 1;
  localparam int unsigned MODE_ECF  = 0;
  // pwm_control_reg bits
  localparam int unsigned PWM_ARSEL = 7;
  localparam int unsigned PWM_INTERMEDIATE_OVERFLOW_IRQ_ENABLE  = 6;
  localparam int unsigned PWM_INTERMEDIATE_OVERFLOW_FLAG  = 5;
  localparam int unsigned PWM_CL    = 0;
  // channel_mode_reg bits
  localparam int unsigned CM_PWM16 = 7;
  localparam int unsigned CM_ECOM  = 6;
  localparam int unsigned CM_CAPP  = 5;
  localparam int unsigned CM_CAPN  = 4;
  localparam int unsigned CM_MAT   = 3;
  localparam int unsigned CM_TOG   = 2;
  localparam int unsigned CM_PWM   = 1;
  localparam int unsigned CM_ECCF  = 0;

  typedef enum logic [2:0] {
    TB_DIV12 = 3'h0,
    TB_DIV4  = 3'h1,
    TB_T0OVF = 3'h2,
    TB_ECI   = 3'h3,
    TB_SYS   = 3'h4,
    TB_XOSC8 = 3'h5,
    TB_RTC8  = 3'h6,
    TB_RSVD  = 3'h7
  } cca_tb_t;

  localparam logic [3:0]  PRE_DIV12   = 4'hC;
  localparam logic [1:0]  PRE_DIV4_AT = 2'h3;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] LOW8_MASK   = 16'h00FF;
  localparam logic [15:0] FULL_MASK   = 16'hFFFF;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : cca_pkg

//--- rtl/cca_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser, one bit per lane
module cca_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : cca_sync

`default_nettype wire

//--- rtl/cca_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: reading counter low byte snapshots high byte; high read returns snapshot
// R2: three-bit timebase_select picks the count source
// R3: external count input must not toggle faster than clock/4
// R4: divided oscillator timebases are synchronised before counting
// R5: counter wrap from FFFF to 0000 sets overflow flag
// R6: flags only cleared by software writes, never by servicing
// R7: with idle_stop_control clear, counter keeps running in idle
// R8: intermediate overflow flag set on overflow of bit 8..11
// R9: five flags set on trigger regardless of enables
// R10: interrupt asserts when any flag and its enable are set
// R11: capture mode uses bit5 rising, bit4 falling, both any edge
// R12: bit3 timer, bits3+2 high-speed, bits2+1 frequency output
// R13: bit1 PWM, bit7 selects 16-bit, shared cycle length field
// R14: all 8..11-bit PWM channels share one cycle length
// R15: comparator off stops toggling and holds PWM output low
// R16: pwm_control_reg bit7 steers to auto-reload registers
// R17: match_flag_enable makes comparator matches set channel flag
// R18: capture edge loads counter into channel register, sets flag
// R19: channel input levels held under two cycles are ignored
// R20: current channel pin levels stay readable by software
// R21: timer mode: 16-bit equality sets channel flag
// R22: low byte write clears comparator_enable, high byte write sets it
// R23: software should write low byte before high byte
// R24: counter steps by one per timebase event, all on clock
module cca_top
  import cca_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [NUM_CH-1:0]   channel_pin_in,
  output logic      [NUM_CH-1:0]   channel_pin_out,
  output logic      [NUM_CH-1:0]   channel_pin_oe,
  input  wire logic                external_count_input,
  input  wire logic                ext_osc_div8,
  input  wire logic                rtc_osc_div8,
  input  wire logic                timer0_overflow,
  input  wire logic                cpu_idle,
  output logic                     irq_request
);

  // write channel: address and data held until both present
  logic              awHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic              wHeld_q;
  logic [7:0]        wByte_q;
  logic              wLane_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;

  wire doWr = awHeld_q & wHeld_q & ~bvalid_q;
  wire doRd = s_axi_arvalid & ~rvalid_q;
  // narrow registers live in byte lane 0; other lanes are ignored
  wire wrOn = doWr & wLane_q;

  assign s_axi_awready = ~awHeld_q;
  assign s_axi_wready  = ~wHeld_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q  <= 1'b0;
      wByte_q  <= 8'h00;
      wLane_q  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && !awHeld_q)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      else if (doWr)
        awHeld_q <= 1'b0;
      if (s_axi_wvalid && !wHeld_q)
      begin
        wHeld_q <= 1'b1;
        wByte_q <= s_axi_wdata[7:0];
        wLane_q <= s_axi_wstrb[0];
      end
      else if (doWr)
        wHeld_q <= 1'b0;
    end
  end

  // control registers
  logic        run_q;
  logic        idleStop_q;
  cca_tb_t     tbSel_q;
  logic        ecf_q;
  logic        cf_q;
  logic        arsel_q;
  logic        intermediate_overflow_irq_enable_q;
  logic        intermediate_overflow_flag_q;
  logic [1:0]  cycLen_q;
  logic [15:0] cnt_q;
  logic [7:0]  snap_q;
  logic        tickD_q;
  logic [3:0]  pre_q;

  wire wrCtrl = wrOn & (awAddr_q == OFS_CTRL);
  wire wrMode = wrOn & (awAddr_q == OFS_MODE);
  wire wrCntL = wrOn & (awAddr_q == OFS_CNTL);
  wire wrCntH = wrOn & (awAddr_q == OFS_CNTH);
  wire wrPwm  = wrOn & (awAddr_q == OFS_PWM);
  wire rdCntL = doRd & (s_axi_araddr == OFS_CNTL);

  // synchronised pins: channels, count input, divided oscillators
  logic [NUM_CH+2:0] pinSync;
  logic              eciLvl_q;
  logic              eciPrev_q;
  logic              xoscPrev_q;
  logic              rtcPrev_q;

  // R4: oscillator dividers cross through two flops
  cca_sync #(
    .W (NUM_CH + 3)
  ) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({rtc_osc_div8, ext_osc_div8, external_count_input, channel_pin_in}),
    .sync_out (pinSync)
  );

  wire eciSync  = pinSync[NUM_CH];
  wire xoscSync = pinSync[NUM_CH+1];
  wire rtcSync  = pinSync[NUM_CH+2];
  wire eciFall  = eciPrev_q & ~eciLvl_q;
  wire xoscRise = xoscSync & ~xoscPrev_q;
  wire rtcRise  = rtcSync & ~rtcPrev_q;
  wire preWrap  = (pre_q == PRE_DIV12 - 4'h1);

  // R2: timebase source selection
  wire srcTick = (tbSel_q == TB_DIV12) ? preWrap :
                 (tbSel_q == TB_DIV4)  ? (pre_q[1:0] == PRE_DIV4_AT) :
                 (tbSel_q == TB_T0OVF) ? timer0_overflow :
                 (tbSel_q == TB_ECI)   ? eciFall :
                 (tbSel_q == TB_SYS)   ? 1'b1 :
                 (tbSel_q == TB_XOSC8) ? xoscRise :
                 (tbSel_q == TB_RTC8)  ? rtcRise : 1'b0;
  // R7: idle only halts counting when idle_stop_control is set
  wire tick = run_q & ~(cpu_idle & idleStop_q) & srcTick & ~(wrCntL | wrCntH);

  // R8: mask of the low 8..11 bits per pwm_cycle_length
  wire [15:0] clMask = {5'h00, cycLen_q == 2'h3, cycLen_q[1], |cycLen_q, 8'hFF};
  // R5: wrap out of FFFF
  wire ovfEv  = tick & (cnt_q == CNT_MAX);
  wire covfEv = tick & ((cnt_q & clMask) == clMask);
  wire nWrap  = tickD_q & ((cnt_q & clMask) == 16'h0000);
  wire fWrap  = tickD_q & (cnt_q == 16'h0000);

  logic [NUM_CH-1:0] chFlag;
  logic [NUM_CH-1:0] chIrqEn;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pre_q      <= 4'h0;
      eciLvl_q   <= 1'b0;
      eciPrev_q  <= 1'b0;
      xoscPrev_q <= 1'b0;
      rtcPrev_q  <= 1'b0;
      tickD_q    <= 1'b0;
    end
    else
    begin
      pre_q      <= preWrap ? 4'h0 : pre_q + 4'h1;
      eciPrev_q  <= eciLvl_q;
      xoscPrev_q <= xoscSync;
      rtcPrev_q  <= rtcSync;
      tickD_q    <= tick;
      // R3: eciLvl_q follows the synchronised input each cycle, so a short glitch is counted
      if (eciSync == pinSync[NUM_CH] && eciSync != eciLvl_q)
        eciLvl_q <= eciSync;
    end
  end

  // R24: one step per timebase event; R1: reads never touch the count
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cnt_q <= 16'h0000;
    else if (wrCntL)
      cnt_q[7:0] <= wByte_q;
    else if (wrCntH)
      cnt_q[15:8] <= wByte_q;
    else if (tick)
      cnt_q <= cnt_q + 16'h0001;
  end

  // R1: low byte read freezes the high byte
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      snap_q <= 8'h00;
    else if (rdCntL)
      snap_q <= cnt_q[15:8];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      run_q      <= 1'b0;
      idleStop_q <= 1'b0;
      tbSel_q    <= TB_DIV12;
      ecf_q      <= 1'b0;
      arsel_q    <= 1'b0;
      intermediate_overflow_irq_enable_q     <= 1'b0;
      cycLen_q   <= 2'h0;
    end
    else
    begin
      if (wrCtrl)
        run_q <= wByte_q[CTRL_RUN];
      if (wrMode)
      begin
        idleStop_q <= wByte_q[MODE_IDLE];
        tbSel_q    <= cca_tb_t'(wByte_q[MODE_TB +: 3]);
        ecf_q      <= wByte_q[MODE_ECF];
      end
      if (wrPwm)
      begin
        arsel_q  <= wByte_q[PWM_ARSEL];
        intermediate_overflow_irq_enable_q   <= wByte_q[PWM_INTERMEDIATE_OVERFLOW_IRQ_ENABLE];
        cycLen_q <= wByte_q[PWM_CL +: 2];
      end
    end
  end

  // R6 R9: set wins over a software clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cf_q   <= 1'b0;
      intermediate_overflow_flag_q <= 1'b0;
    end
    else
    begin
      cf_q   <= ovfEv | (wrCtrl ? wByte_q[CTRL_CF] : cf_q);
      intermediate_overflow_flag_q <= covfEv | (wrPwm ? wByte_q[PWM_INTERMEDIATE_OVERFLOW_FLAG] : intermediate_overflow_flag_q);
    end
  end

  // R10: one request from flags gated by their own enables
  assign irq_request = (cf_q & ecf_q) | (intermediate_overflow_flag_q & intermediate_overflow_irq_enable_q) | (|(chFlag & chIrqEn));

  logic [NUM_CH-1:0] chHit;
  logic [7:0]        chRd [NUM_CH];
  logic [NUM_CH-1:0] pinLvl;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      localparam logic [7:0] BASE = OFS_CH_BASE + CH_STRIDE * 8'(gi);
      logic [7:0]  mode_q;
      logic [15:0] cc_q;
      logic [15:0] ar_q;
      logic        out_q;
      logic        flag_q;
      logic        lvl_q;
      logic        lvlPrev_q;

      wire wrCm  = wrOn & (awAddr_q == BASE + CH_OFS_MODE);
      wire wrLo  = wrOn & (awAddr_q == BASE + CH_OFS_LOW);
      wire wrHi  = wrOn & (awAddr_q == BASE + CH_OFS_HIGH);
      wire ecom  = mode_q[CM_ECOM];
      wire tog   = mode_q[CM_TOG];
      wire pwm   = mode_q[CM_PWM];
      wire freq  = tog & pwm;
      wire hso   = tog & ~pwm;
      wire pwm16 = pwm & ~tog & mode_q[CM_PWM16];
      wire pwmN  = pwm & ~tog & ~mode_q[CM_PWM16];
      // R14: every 8..11-bit channel uses the shared clMask
      wire [15:0] cmpMask = freq ? LOW8_MASK : (pwmN ? clMask : FULL_MASK);
      // R21 R15: comparator matches only while enabled
      wire hit   = ecom & tickD_q & (((cnt_q ^ cc_q) & cmpMask) == 16'h0000);
      wire wrap  = pwm16 ? fWrap : nWrap;
      wire rise  = lvl_q & ~lvlPrev_q;
      wire fall  = lvlPrev_q & ~lvl_q;
      // R11: capture edge select
      wire capEv = (mode_q[CM_CAPP] & rise) | (mode_q[CM_CAPN] & fall);
      // R17 R18: flag on capture or enabled match
      wire setEv = capEv | (hit & mode_q[CM_MAT]);
      wire clrWr = wrCtrl ? wByte_q[gi] : flag_q;

      // R19: level accepted only after two equal samples
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          lvl_q     <= 1'b0;
          lvlPrev_q <= 1'b0;
        end
        else
        begin
          lvlPrev_q <= lvl_q;
          if (pinSync[gi] == pinLvl[gi])
            lvl_q <= pinSync[gi];
        end
      end

      always_ff @(posedge clock)
      begin
        if (!rst_n)
          pinLvl[gi] <= 1'b0;
        else
          pinLvl[gi] <= pinSync[gi];
      end

      always_ff @(posedge clock)
      begin
        if (!rst_n)
          flag_q <= 1'b0;
        else
          flag_q <= setEv | clrWr;
      end

      // R22: byte writes steer comparator_enable
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          mode_q <= 8'h00;
        else if (wrCm)
          mode_q <= wByte_q;
        else if (wrLo)
          mode_q[CM_ECOM] <= 1'b0;
        else if (wrHi)
          mode_q[CM_ECOM] <= 1'b1;
      end

      // R16: bit7 of pwm_control_reg picks the auto-reload copy
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          ar_q <= 16'h0000;
        else if (wrLo && arsel_q)
          ar_q[7:0] <= wByte_q;
        else if (wrHi && arsel_q)
          ar_q[15:8] <= wByte_q;
      end

      always_ff @(posedge clock)
      begin
        if (!rst_n)
          cc_q <= 16'h0000;
        else if (wrLo && !arsel_q)
          cc_q[7:0] <= wByte_q;
        else if (wrHi && !arsel_q)
          cc_q[15:8] <= wByte_q;
        else if (capEv)
          cc_q <= cnt_q;
        else if (freq && hit)
          cc_q[7:0] <= cc_q[7:0] + cc_q[15:8];
        else if (pwmN && nWrap)
          cc_q <= (cycLen_q == 2'h0) ? {cc_q[15:8], cc_q[15:8]} : ar_q;
      end

      // R15 R13 R12: output per mode; hit wins so zero compare is full duty
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          out_q <= 1'b0;
        else if (pwm && !tog && !ecom)
          out_q <= 1'b0;
        else if ((hso || freq) && hit)
          out_q <= ~out_q;
        else if (pwm && !tog && hit)
          out_q <= 1'b1;
        else if (pwm && !tog && wrap)
          out_q <= 1'b0;
      end

      assign channel_pin_out[gi] = out_q;
      assign channel_pin_oe[gi]  = tog | pwm;
      assign chFlag[gi]          = flag_q;
      assign chIrqEn[gi]         = mode_q[CM_ECCF];

      wire rdCm = s_axi_araddr == BASE + CH_OFS_MODE;
      wire rdLo = s_axi_araddr == BASE + CH_OFS_LOW;
      wire rdHi = s_axi_araddr == BASE + CH_OFS_HIGH;
      wire [15:0] rdSrc = arsel_q ? ar_q : cc_q;
      assign chHit[gi] = rdCm | rdLo | rdHi;
      assign chRd[gi]  = rdCm ? mode_q : (rdLo ? rdSrc[7:0] : (rdHi ? rdSrc[15:8] : 8'h00));
    end
  endgenerate

  wire [7:0] chRdAll = chRd[0] | chRd[1] | chRd[2];
  wire [7:0] ctrlRd  = {cf_q, run_q, {(6 - NUM_CH){1'b0}}, chFlag};
  wire [7:0] modeRd  = {idleStop_q, 3'h0, tbSel_q, ecf_q};
  wire [7:0] pwmRd   = {arsel_q, intermediate_overflow_irq_enable_q, intermediate_overflow_flag_q, 3'h0, cycLen_q};
  // R20: live pin levels for telling which edge fired
  wire [7:0] pinsRd  = {{(8 - NUM_CH){1'b0}}, lvl_all()};

  function automatic logic [NUM_CH-1:0] lvl_all();
    lvl_all = pinLvl;
  endfunction : lvl_all

  wire rdCtrl = s_axi_araddr == OFS_CTRL;
  wire rdMode = s_axi_araddr == OFS_MODE;
  wire rdCntH = s_axi_araddr == OFS_CNTH;
  wire rdLowC = s_axi_araddr == OFS_CNTL;
  wire rdPwm  = s_axi_araddr == OFS_PWM;
  wire rdPins = s_axi_araddr == OFS_PINS;
  wire rdMap  = rdCtrl | rdMode | rdCntH | rdLowC | rdPwm | rdPins | (|chHit);
  wire [7:0] rdByte = rdCtrl ? ctrlRd : rdMode ? modeRd : rdLowC ? cnt_q[7:0] :
                      rdCntH ? snap_q : rdPwm ? pwmRd : rdPins ? pinsRd : chRdAll;

  wire wrMap = (awAddr_q == OFS_CTRL) | (awAddr_q == OFS_MODE) | (awAddr_q == OFS_CNTL) |
               (awAddr_q == OFS_CNTH) | (awAddr_q == OFS_PWM) | (awAddr_q == OFS_PINS) |
               ((awAddr_q >= OFS_CH_BASE) &&
                (awAddr_q < OFS_CH_BASE + CH_STRIDE * NUM_CH[7:0]) &&
                (awAddr_q[3:0] <= CH_OFS_HIGH[3:0]) && (awAddr_q[1:0] == 2'h0));

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else
    begin
      if (doWr)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wrMap ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      if (doRd)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= {{(DATA_W - 8){1'b0}}, rdMap ? rdByte : 8'h00};
        rresp_q  <= rdMap ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

endmodule : cca_top

`default_nettype wire

//--- test/cca_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module cca_pin_model
  import cca_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [NUM_CH-1:0] pinLevel,
  input  wire logic [NUM_CH-1:0] glitchPin,
  input  wire logic              eciStep,
  output logic      [NUM_CH-1:0] channel_pin_in,
  output logic                   external_count_input
);
  logic [2:0] eciLeft_q;
  // levels held as asked; a glitch only when commanded
  always_ff @(posedge clock) channel_pin_in <= pinLevel ^ glitchPin;
  // low phase of four cycles keeps the rate under clock/4
  always_ff @(posedge clock)
  begin
    if (!rst_n) eciLeft_q <= 3'h0;
    else if (eciStep) eciLeft_q <= 3'h4;
    else if (eciLeft_q != 3'h0) eciLeft_q <= eciLeft_q - 3'h1;
  end
  // idles high so only commanded falls count
  assign external_count_input = (eciLeft_q == 3'h0);
endmodule : cca_pin_model
`default_nettype wire

//--- test/cca_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cca_top_asserts
  import cca_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [NUM_CH-1:0] channel_pin_oe,
  input wire logic              irq_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_arready_gate: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_reset_quiet: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid
    && !irq_request && channel_pin_oe == 3'h0) else $error("outputs busy after reset");
  a_irq_sw_clear: assert property ($fell(irq_request) |-> $rose(s_axi_bvalid))
    else $error("request dropped without a write");
endmodule : cca_top_asserts

bind cca_top cca_top_asserts u_cca_chk (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .channel_pin_oe, .irq_request);
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checkCount++; if ((s) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", nm, e, s); end end
module tb;
  import cca_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} cca_row_t;
  logic                clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready, external_count_input, ext_osc_div8;
  logic                rtc_osc_div8, timer0_overflow, cpu_idle, irq_request, eciStep;
  logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
  logic [DATA_W/8-1:0] s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp, rs;
  logic [NUM_CH-1:0]   channel_pin_in, channel_pin_out, channel_pin_oe, pinLevel, glitchPin;
  logic [7:0]          rv;
  int                  miscompares, checkCount, lo;
  cca_row_t rows [7] = '{'{8'h04, 8'h8F, 8'h8F, RESP_OKAY}, '{8'h10, 8'h43, 8'h43, RESP_OKAY},
    '{8'h10, 8'h80, 8'h80, RESP_OKAY}, '{8'h10, 8'h00, 8'h00, RESP_OKAY},
    '{8'h30, 8'h30, 8'h30, RESP_OKAY}, '{8'h40, 8'h0C, 8'h0C, RESP_OKAY},
    '{8'hFC, 8'h55, 8'h00, RESP_SLVERR}};
  logic [2:0] sels [7] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h3, 3'h5, 3'h6};
  int divs [7] = '{12, 4, 1, 0, 0, 0, 0};
  cca_top dut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .channel_pin_in, .channel_pin_out, .channel_pin_oe, .external_count_input,
    .ext_osc_div8, .rtc_osc_div8, .timer0_overflow, .cpu_idle, .irq_request);
  cca_pin_model u_pins (.clock, .rst_n, .pinLevel, .glitchPin, .eciStep, .channel_pin_in,
    .external_count_input);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50)
    begin
      miscompares++;
      finish_test();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rv = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50)
    begin
      miscompares++;
      finish_test();
    end
  endtask : rd
  // ev zero means a fixed 108-clock run window on a clock-derived source
  task automatic count_src(input logic [2:0] sel, input int ev);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CNTL, 8'h00);
    wr(OFS_CNTH, 8'h00);
    wr(OFS_MODE, {4'h0, sel, 1'b0});
    wr(OFS_CTRL, 8'h40);
    if (ev == 0) cyc(96);
    repeat (ev)
    begin
      @(posedge clock);
      case (sel)
        3'h2: timer0_overflow <= 1'b1;
        3'h3: eciStep <= 1'b1;
        3'h5: ext_osc_div8 <= 1'b1;
        default: rtc_osc_div8 <= 1'b1;
      endcase
      @(posedge clock);
      timer0_overflow <= 1'b0;
      eciStep <= 1'b0;
      cyc(3);
      ext_osc_div8 <= 1'b0;
      rtc_osc_div8 <= 1'b0;
      cyc(6);
    end
    cyc(8);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_CNTL);
  endtask : count_src
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {ext_osc_div8, rtc_osc_div8, timer0_overflow, eciStep} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {pinLevel, glitchPin} = 6'h00;
    s_axi_wstrb = 4'hF;
    cpu_idle = 1'b1;
    rst_n = 1'b0;
    miscompares = 0;
    checkCount = 0;
    cyc(2);
    rst_n <= 1'b1;
    rd(OFS_MODE);
    `CHK("mode after reset", 8'h00, rv)
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      `CHK("write resp", rows[i].r, rs)
      rd(rows[i].a);
      `CHK("readback", rows[i].e, rv)
      `CHK("read resp", rows[i].r, rs)
    end
    // idle input high throughout: counting must carry on
    foreach (sels[i])
    begin
      count_src(sels[i], (divs[i] == 0) ? 5 : 0);
      // run bit stands 108 clocks, a whole number of prescaler periods
      lo = (divs[i] == 0) ? 5 : 108 / divs[i];
      `CHK("count", lo, rv)
    end
    wr(OFS_CNTL, 8'hF0);
    wr(OFS_CNTH, 8'hFF);
    wr(OFS_MODE, 8'h09);
    wr(OFS_CTRL, 8'h40);
    cyc(40);
    rd(OFS_CTRL);
    `CHK("wrap flag", 8'hC0, rv)
    rd(OFS_PWM);
    `CHK("mid flag", 8'h20, rv)
    `CHK("irq set", 1'b1, irq_request)
    wr(OFS_CTRL, 8'h40);
    rd(OFS_CTRL);
    `CHK("wrap cleared", 8'h40, rv)
    `CHK("irq gated", 1'b0, irq_request)
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CNTL, 8'hFF);
    wr(OFS_CNTH, 8'h12);
    rd(OFS_CNTL);
    `CHK("low", 8'hFF, rv)
    wr(OFS_CNTH, 8'h34);
    rd(OFS_CNTH);
    `CHK("snapshot", 8'h12, rv)
    wr(8'h20, 8'h49);
    wr(8'h24, 8'h20);
    rd(8'h20);
    `CHK("low write", 8'h09, rv)
    wr(8'h28, 8'h00);
    rd(8'h20);
    `CHK("high write", 8'h49, rv)
    wr(OFS_CNTL, 8'h00);
    wr(OFS_CNTH, 8'h00);
    wr(OFS_MODE, 8'h08);
    wr(OFS_CTRL, 8'h40);
    cyc(60);
    rd(OFS_CTRL);
    `CHK("match flag", 8'h41, rv)
    `CHK("irq match", 1'b1, irq_request)
    wr(8'h20, 8'h00);
    wr(8'h40, 8'h30);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CNTL, 8'h00);
    wr(OFS_CTRL, 8'h40);
    cyc(20);
    pinLevel <= 3'b010;
    cyc(10);
    rd(OFS_PINS);
    `CHK("pins", 3'b010, rv[2:0])
    rd(OFS_CTRL);
    `CHK("cap flag", 3'b010, rv[2:0])
    rd(8'h34);
    `CHK("cap value", 1'b1, (rv > 8'h10 && rv < 8'h60))
    @(posedge clock);
    glitchPin <= 3'b100;
    @(posedge clock);
    glitchPin <= 3'b000;
    cyc(10);
    rd(OFS_CTRL);
    `CHK("glitch", 1'b0, rv[2])
    pinLevel <= 3'b110;
    cyc(10);
    rd(OFS_CTRL);
    `CHK("held edge", 1'b1, rv[2])
    wr(8'h20, 8'h02);
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h00); // low byte first
    cyc(300);
    `CHK("pwm full", 1'b1, channel_pin_out[0])
    wr(8'h24, 8'h00);
    cyc(2);
    `CHK("pwm off", 1'b0, channel_pin_out[0])
    finish_test();
  end
endmodule : tb
`default_nettype wire
